/* File: verilog/obl_pkg.sv */
/*
 * Shared constants and types of the option byte loader.
 * Assumes a 64 KB program flash of 128 pages of 512 bytes each.
 */
package obl_pkg;

   // ------------------------------------------------------------
   // Option byte locations and erased value
   // ------------------------------------------------------------
   localparam logic [15:0] OPT_ADDR_USER = 16'h0000; // Active options
   localparam logic [15:0] OPT_ADDR_RSVD = 16'h0001; // Reserved byte
   localparam logic [7:0]  OPT_ERASED    = 8'hFF;    // Unprogrammed

   // ------------------------------------------------------------
   // Field positions in the user option byte
   // ------------------------------------------------------------
   localparam int BIT_WD_ACTION = 7; // 1: short reset, 0: interrupt
   localparam int BIT_WD_ALWAYS = 6; // 0: watchdog always on
   localparam int BIT_READ_PROT = 2; // 0: code read protected
   localparam int BIT_HIGH_ONLY = 1; // High sector writable
   localparam int BIT_FULL_WR   = 0; // Whole array writable

   // ------------------------------------------------------------
   // APB register offsets and status bits
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_FLASH_CMD = 12'h000; // Cmd / lock state
   localparam logic [11:0] OFS_PAGE_SEL  = 12'h004; // Erase page
   localparam logic [11:0] OFS_STATUS    = 12'h008; // Loader status
   localparam int STAT_LOADED   = 0; // Option load complete
   localparam int STAT_RSVD_OK  = 1; // Reserved byte still erased
   localparam int STAT_REFUSED  = 2; // Sticky refused request, W1C
   localparam int STAT_WD_RUN   = 3; // Watchdog running

   // ------------------------------------------------------------
   // Flash command codes and lock state codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_UNLOCK1    = 8'h73;
   localparam logic [7:0] CMD_UNLOCK2    = 8'h8C;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
   localparam logic [5:0] FST_LOCKED     = 6'h00;
   localparam logic [5:0] FST_FIRST      = 6'h01;
   localparam logic [5:0] FST_UNLOCKED   = 6'h02;

   // ------------------------------------------------------------
   // Page geometry: high sector is the top 4 KB
   // ------------------------------------------------------------
   localparam int          PAGE_LSB        = 9;
   localparam logic [6:0]  HIGH_FIRST_PAGE = 7'h78;

   // ------------------------------------------------------------
   // State types
   // ------------------------------------------------------------
   typedef enum {OBL_LD_BYTE0, OBL_LD_GAP, OBL_LD_BYTE1, OBL_LD_IDLE}
      obl_ld_e;
   typedef enum {OBL_FC_LOCKED, OBL_FC_FIRST, OBL_FC_UNLOCKED}
      obl_fc_e;

endpackage

/* File: verilog/obl_prot_if.sv */
/*
 * Request and decision lane between the loader top and a
 * protection checker. Assumes one request per cycle at most.
 */
`timescale 1ns/1ps
interface obl_prot_if;
   logic       reqValid;  // Request present this cycle
   logic       reqMass;   // Mass erase, else program or page erase
   logic       reqDebug;  // Request comes from the debug unit
   logic [6:0] reqPage;   // Targeted page
   logic       fullWrite; // Loaded full write permit
   logic       highOnly;  // Loaded high sector only writable
   logic       grant;     // Request allowed, one cycle later
   logic       refuse;    // Request refused, one cycle later

   modport asker (output reqValid, reqMass, reqDebug, reqPage,
                  output fullWrite, highOnly,
                  input  grant, refuse);
   modport judge (input  reqValid, reqMass, reqDebug, reqPage,
                  input  fullWrite, highOnly,
                  output grant, refuse);
endinterface

/* File: verilog/obl_prot_check.sv */
/*
 * Protection checker: judges one program or erase request per
 * cycle against the loaded protection options.
 * Assumes the requester holds request fields for that cycle only.
 */
`timescale 1ns/1ps
module obl_prot_check (
   input wire logic clk,
   input wire logic rst_b,
   obl_prot_if.judge prot
);

   logic allow;    // Decision for the present request
   logic inHigh;   // Page lies in the high sector
   logic grant_d;  // Next grant pulse
   logic grant_q;  // Grant pulse
   logic refuse_d; // Next refuse pulse
   logic refuse_q; // Refuse pulse

   // ------------------------------------------------------------
   // Decision
   // ------------------------------------------------------------
   // Whole page number compared with the high sector base
   always_comb begin
      inHigh = (prot.reqPage >= obl_pkg::HIGH_FIRST_PAGE);
      if (prot.fullWrite) begin
         allow = 1'b1;
      end else if (prot.reqMass) begin
         allow = prot.reqDebug;
      end else begin
         allow = prot.highOnly & inHigh;
      end
      grant_d  = prot.reqValid & allow;
      refuse_d = prot.reqValid & ~allow;
   end

   // Registers the decision pulses
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         grant_q  <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         grant_q  <= grant_d;
         refuse_q <= refuse_d;
      end
   end

   assign prot.grant  = grant_q;
   assign prot.refuse = refuse_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_full_permit: assert property (
      prot.reqValid && prot.fullWrite |=> prot.grant && !prot.refuse)
      else $error("full write permit did not grant");
   a_user_mass_block: assert property (
      prot.reqValid && prot.reqMass && !prot.reqDebug
      && !prot.fullWrite |=> prot.refuse)
      else $error("user mass erase not refused");
   a_low_page_block: assert property (
      prot.reqValid && !prot.reqMass && !prot.fullWrite
      && prot.reqPage < obl_pkg::HIGH_FIRST_PAGE |=> prot.refuse)
      else $error("low page write not refused");
   a_high_page_ok: assert property (
      prot.reqValid && !prot.reqMass && prot.highOnly
      && prot.reqPage >= obl_pkg::HIGH_FIRST_PAGE |=> prot.grant)
      else $error("high sector write not granted");
   a_one_answer: assert property (
      prot.reqValid |=> (prot.grant != prot.refuse))
      else $error("request without single answer");
   c_refused: cover property (prot.refuse);

endmodule

/* File: verilog/obl_option_loader.sv */
/*
 * Option byte loader: fetches the option byte from program flash
 * on every reset type, applies watchdog, read and write
 * protection options, and gates flash program and erase requests.
 * Assumes a same-clock flash read port answering with one valid
 * pulse per read, and same-clock reset and request pulses.
 */
`timescale 1ns/1ps
module obl_option_loader (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output wire logic [31:0] prdata,
   output wire logic        pready,
   output wire logic        pslverr,
   input  wire logic        shortResetReq,
   input  wire logic        stopRecovery,
   output wire logic        flashRdReq,
   output wire logic [15:0] flashRdAddr,
   input  wire logic [7:0]  flashRdData,
   input  wire logic        flashRdValid,
   output wire logic        cpuHold,
   input  wire logic        watchdogStartInstruction,
   output wire logic        watchdogRunning,
   output wire logic        watchdogTimeoutAction,
   output wire logic        watchdogAlwaysOnN,
   output wire logic        codeReadProtectN,
   output wire logic        highSectorOnlyWritable,
   output wire logic        fullWritePermit,
   input  wire logic        progReq,
   input  wire logic [15:0] progAddr,
   output wire logic        progGrant,
   output wire logic        progRefuse,
   input  wire logic        debugMassErase,
   output wire logic        eraseStart,
   output wire logic        eraseMass,
   output wire logic [6:0]  erasePage,
   output wire logic        eraseRefuse
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   obl_pkg::obl_ld_e ldState_q;   // Loader state
   obl_pkg::obl_ld_e ldState_d;
   obl_pkg::obl_fc_e fcState_q;   // Flash command lock state
   obl_pkg::obl_fc_e fcState_d;
   logic [7:0]  cfg_q;            // Hidden option configuration
   logic [7:0]  cfg_d;
   logic        rsvdOk_q;         // Reserved byte read as erased
   logic        rsvdOk_d;
   logic        cpuHold_q;        // Processor held in reset
   logic        cpuHold_d;
   logic        rdReq_q;          // Flash read request
   logic        rdReq_d;
   logic [15:0] rdAddr_q;         // Flash read address
   logic [15:0] rdAddr_d;
   logic        wdRun_q;          // Watchdog running
   logic        wdRun_d;
   logic [6:0]  pageSel_q;        // Erase page select
   logic [6:0]  pageSel_d;
   logic        refused_q;        // Sticky refused flag
   logic        refused_d;
   logic        ersMass_q;        // Mass flag of last erase request
   logic        ersMass_d;
   logic [6:0]  ersPage_q;        // Page of last erase request
   logic [6:0]  ersPage_d;
   logic        ersReq;           // Erase lane request
   logic        ersMassReq;       // Erase lane mass flag
   logic        ersDbgReq;        // Erase lane from debug unit
   logic [5:0]  fcCode;           // Lock state as read back
   logic        pready_q;         // Access phase ready
   logic        pready_d;
   logic [31:0] prdata_q;         // Read data
   logic [31:0] prdata_d;
   logic        pslverr_q;        // Unmapped access
   logic        pslverr_d;
   logic        reload;           // Short reset or stop recovery
   logic        access;           // APB access completes
   logic        cmdWr;            // Write to flash command
   logic        pageWr;           // Write to page select
   logic        statWr;           // Write to status

   obl_prot_if progIf ();         // Program lane
   obl_prot_if eraseIf ();        // Erase lane

   assign reload = shortResetReq | stopRecovery;
   assign access = psel & penable & pready_q;
   assign cmdWr  = access & pwrite & (paddr == obl_pkg::OFS_FLASH_CMD);
   assign pageWr = access & pwrite & (paddr == obl_pkg::OFS_PAGE_SEL);
   assign statWr = access & pwrite & (paddr == obl_pkg::OFS_STATUS);

   // ------------------------------------------------------------
   // Option load sequence
   // ------------------------------------------------------------
   // Reads 0000H then 0001H; the flash is only ever read here
   always_comb begin
      ldState_d = ldState_q;
      cfg_d     = cfg_q;
      rsvdOk_d  = rsvdOk_q;
      wdRun_d   = wdRun_q;
      case (ldState_q)
         obl_pkg::OBL_LD_BYTE0: begin
            if (flashRdValid) begin
               cfg_d     = flashRdData;
               ldState_d = obl_pkg::OBL_LD_GAP;
            end
         end
         obl_pkg::OBL_LD_GAP: begin
            ldState_d = obl_pkg::OBL_LD_BYTE1;
         end
         obl_pkg::OBL_LD_BYTE1: begin
            if (flashRdValid) begin
               rsvdOk_d  = (flashRdData == obl_pkg::OPT_ERASED);
               ldState_d = obl_pkg::OBL_LD_IDLE;
            end
         end
         obl_pkg::OBL_LD_IDLE: begin
            // Options hold until the next reset of any type
            if (!cfg_q[obl_pkg::BIT_WD_ALWAYS]) begin
               wdRun_d = 1'b1;
            end else if (watchdogStartInstruction) begin
               wdRun_d = 1'b1;
            end
         end
         default: ldState_d = obl_pkg::OBL_LD_BYTE0;
      endcase
      if (reload) begin
         ldState_d = obl_pkg::OBL_LD_BYTE0;
         cfg_d     = obl_pkg::OPT_ERASED;
         wdRun_d   = 1'b0;
      end
      cpuHold_d = (ldState_d != obl_pkg::OBL_LD_IDLE);
      rdReq_d   = (ldState_d == obl_pkg::OBL_LD_BYTE0)
                | (ldState_d == obl_pkg::OBL_LD_BYTE1);
      rdAddr_d  = (ldState_d == obl_pkg::OBL_LD_BYTE1)
                ? obl_pkg::OPT_ADDR_RSVD : obl_pkg::OPT_ADDR_USER;
   end

   // Registers the loader; system reset starts a load
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ldState_q <= obl_pkg::OBL_LD_BYTE0;
         cfg_q     <= obl_pkg::OPT_ERASED;
         rsvdOk_q  <= 1'b1;
         cpuHold_q <= 1'b1;
         rdReq_q   <= 1'b1;
         rdAddr_q  <= obl_pkg::OPT_ADDR_USER;
         wdRun_q   <= 1'b0;
      end else begin
         ldState_q <= ldState_d;
         cfg_q     <= cfg_d;
         rsvdOk_q  <= rsvdOk_d;
         cpuHold_q <= cpuHold_d;
         rdReq_q   <= rdReq_d;
         rdAddr_q  <= rdAddr_d;
         wdRun_q   <= wdRun_d;
      end
   end

   // ------------------------------------------------------------
   // Flash command lock and erase requests
   // ------------------------------------------------------------
   // Any wrong value or order relocks the controller
   always_comb begin
      fcState_d  = fcState_q;
      pageSel_d  = pageSel_q;
      refused_d  = refused_q;
      ersMass_d  = ersMass_q;
      ersPage_d  = ersPage_q;
      ersReq     = 1'b0;
      ersMassReq = 1'b0;
      ersDbgReq  = 1'b0;
      if (cmdWr) begin
         fcState_d = obl_pkg::OBL_FC_LOCKED;
         case (fcState_q)
            obl_pkg::OBL_FC_LOCKED: begin
               if (pwdata[7:0] == obl_pkg::CMD_UNLOCK1) begin
                  fcState_d = obl_pkg::OBL_FC_FIRST;
               end
            end
            obl_pkg::OBL_FC_FIRST: begin
               if (pwdata[7:0] == obl_pkg::CMD_UNLOCK2) begin
                  fcState_d = obl_pkg::OBL_FC_UNLOCKED;
               end
            end
            obl_pkg::OBL_FC_UNLOCKED: begin
               // Third write starts an erase, then relocks
               ersReq = (pwdata[7:0] == obl_pkg::CMD_PAGE_ERASE)
                      | (pwdata[7:0] == obl_pkg::CMD_MASS_ERASE);
               ersMassReq = (pwdata[7:0] == obl_pkg::CMD_MASS_ERASE);
            end
            default: fcState_d = obl_pkg::OBL_FC_LOCKED;
         endcase
      end else if (debugMassErase) begin
         // Debug unit mass erase shares the erase lane
         ersReq     = 1'b1;
         ersMassReq = 1'b1;
         ersDbgReq  = 1'b1;
      end
      if (ersReq) begin
         ersMass_d = ersMassReq;
         ersPage_d = pageSel_q;
      end
      if (pageWr) begin
         pageSel_d = pwdata[6:0];
      end
      if (statWr && pwdata[obl_pkg::STAT_REFUSED]) begin
         refused_d = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (progIf.refuse || eraseIf.refuse) begin
         refused_d = 1'b1;
      end
      if (reload) begin
         fcState_d = obl_pkg::OBL_FC_LOCKED;
      end
   end

   // Registers the command state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fcState_q <= obl_pkg::OBL_FC_LOCKED;
         pageSel_q <= 7'h00;
         refused_q <= 1'b0;
         ersMass_q <= 1'b0;
         ersPage_q <= 7'h00;
      end else begin
         fcState_q <= fcState_d;
         pageSel_q <= pageSel_d;
         refused_q <= refused_d;
         ersMass_q <= ersMass_d;
         ersPage_q <= ersPage_d;
      end
   end

   // ------------------------------------------------------------
   // Protection lanes
   // ------------------------------------------------------------
   // Program requests are ignored while the processor is held
   assign progIf.reqValid   = progReq & ~cpuHold_q;
   assign progIf.reqMass    = 1'b0;
   assign progIf.reqDebug   = 1'b0;
   assign progIf.reqPage    = progAddr[15:obl_pkg::PAGE_LSB];
   assign progIf.fullWrite  = cfg_q[obl_pkg::BIT_FULL_WR];
   assign progIf.highOnly   = cfg_q[obl_pkg::BIT_HIGH_ONLY];
   assign eraseIf.reqValid  = ersReq;
   assign eraseIf.reqMass   = ersMassReq;
   assign eraseIf.reqDebug  = ersDbgReq;
   assign eraseIf.reqPage   = pageSel_q;
   assign eraseIf.fullWrite = cfg_q[obl_pkg::BIT_FULL_WR];
   assign eraseIf.highOnly  = cfg_q[obl_pkg::BIT_HIGH_ONLY];

   obl_prot_check progCheck (
      .clk   (clk),
      .rst_b (rst_b),
      .prot  (progIf.judge)
   );

   obl_prot_check eraseCheck (
      .clk   (clk),
      .rst_b (rst_b),
      .prot  (eraseIf.judge)
   );

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // One wait-free access phase; read data prepared in setup
   always_comb begin
      case (fcState_q)
         obl_pkg::OBL_FC_FIRST:    fcCode = obl_pkg::FST_FIRST;
         obl_pkg::OBL_FC_UNLOCKED: fcCode = obl_pkg::FST_UNLOCKED;
         default:                  fcCode = obl_pkg::FST_LOCKED;
      endcase
      pready_d  = psel & ~penable;
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            obl_pkg::OFS_FLASH_CMD: prdata_d[5:0] = fcCode;
            obl_pkg::OFS_PAGE_SEL:  prdata_d[6:0] = pageSel_q;
            obl_pkg::OFS_STATUS: begin
               prdata_d[obl_pkg::STAT_LOADED]  = ~cpuHold_q;
               prdata_d[obl_pkg::STAT_RSVD_OK] = rsvdOk_q;
               prdata_d[obl_pkg::STAT_REFUSED] = refused_q;
               prdata_d[obl_pkg::STAT_WD_RUN]  = wdRun_q;
            end
            // Option configuration has no address at all
            default: pslverr_d = 1'b1;
         endcase
      end
   end

   // Registers the bus answer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= pready_d;
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign flashRdReq  = rdReq_q; // Read only: options never rewritten
   assign flashRdAddr = rdAddr_q;
   assign cpuHold     = cpuHold_q;
   assign watchdogRunning        = wdRun_q;
   assign watchdogTimeoutAction  = cfg_q[obl_pkg::BIT_WD_ACTION];
   assign watchdogAlwaysOnN      = cfg_q[obl_pkg::BIT_WD_ALWAYS];
   assign codeReadProtectN       = cfg_q[obl_pkg::BIT_READ_PROT];
   assign highSectorOnlyWritable = cfg_q[obl_pkg::BIT_HIGH_ONLY];
   assign fullWritePermit        = cfg_q[obl_pkg::BIT_FULL_WR];
   assign progGrant   = progIf.grant;
   assign progRefuse  = progIf.refuse;
   assign eraseStart  = eraseIf.grant;
   assign eraseRefuse = eraseIf.refuse;
   assign eraseMass   = ersMass_q;
   assign erasePage   = ersPage_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_reload_erased: assert property (
      reload |=> cpuHold_q && cfg_q == obl_pkg::OPT_ERASED && rdReq_q)
      else $error("reload did not restart option load");
   a_cfg_frozen: assert property (
      ldState_q == obl_pkg::OBL_LD_IDLE && !reload |=> $stable(cfg_q))
      else $error("options changed without reset");
   a_hold_loading: assert property (
      ldState_q != obl_pkg::OBL_LD_IDLE |-> cpuHold_q)
      else $error("processor released before load");
   a_user_addr: assert property (
      ldState_q == obl_pkg::OBL_LD_BYTE0 && flashRdValid && !reload
      |-> rdAddr_q == obl_pkg::OPT_ADDR_USER ##1 cfg_q == $past(flashRdData))
      else $error("option byte not taken from 0000H");
   a_wd_forced: assert property (
      !cpuHold_q && !cfg_q[obl_pkg::BIT_WD_ALWAYS] && !reload |=> wdRun_q)
      else $error("always-on watchdog not running");
   a_wd_sticky: assert property (
      wdRun_q && !reload |=> wdRun_q)
      else $error("watchdog stopped without reset");
   a_erase_relock: assert property (
      cmdWr && fcState_q == obl_pkg::OBL_FC_UNLOCKED
      |=> fcState_q == obl_pkg::OBL_FC_LOCKED)
      else $error("controller not relocked after command");
   c_load_done: cover property ($fell(cpuHold_q));
   c_erase_go: cover property (eraseStart && !eraseMass);
   c_wd_start: cover property (!wdRun_q ##1 wdRun_q);

endmodule

/* File: bench/obl_flash_model.sv */
/* Flash read port model holding the two option bytes.
   Assumes the loader holds its request until a valid pulse. */
`timescale 1ns/1ps
module obl_flash_model (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        flashRdReq,
   input  wire logic [15:0] flashRdAddr,
   input  wire logic [7:0]  optByte,
   input  wire logic        slow,
   output logic      [7:0]  flashRdData,
   output logic             flashRdValid
);
   logic [1:0] cnt  = 2'h0; // Cycles waited on this read
   logic       done = 1'b0; // Answered, request not yet dropped
   initial flashRdData = 8'h00;
   initial flashRdValid = 1'b0;
   // One valid pulse per read; slow reads wait three cycles
   always @(posedge clk) begin
      flashRdValid <= 1'b0;
      flashRdData <= ~flashRdData; // Line not driven keeps moving
      if (!rst_b || !flashRdReq) begin
         done <= 1'b0;
         cnt <= 2'h0;
      end else if (!done && cnt < {slow, slow}) begin
         cnt <= cnt + 2'h1;
      end else if (!done) begin
         flashRdValid <= 1'b1;
         // Byte 0 holds options, byte 1 left erased
         flashRdData <= (flashRdAddr == 16'h0000) ? optByte : 8'hFF;
         done <= 1'b1;
      end
   end
endmodule

/* File: bench/option_byte_loader_tb.sv */
/* Bench for the option byte loader: option rows, then erase lane.
   Assumes the flash model and the loader compiled before it. */
`timescale 1ns/1ps
module option_byte_loader_tb;
   typedef struct packed {logic [7:0] opt; logic [6:0] pg; logic ok;}
      obl_row_s;
   obl_row_s rows [5] = '{'{8'hFF, 7'h00, 1'b1}, '{8'hF8, 7'h7F, 1'b0},
      '{8'hFA, 7'h78, 1'b1}, '{8'h3D, 7'h10, 1'b1}, '{8'hFA, 7'h77, 1'b0}};
   logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
   logic shortResetReq = 0, stopRecovery = 0, progReq = 0;
   logic debugMassErase = 0, watchdogStartInstruction = 0, e;
   logic [11:0] paddr = 0;
   logic [15:0] progAddr = 0, flashRdAddr;
   logic [31:0] pwdata = 0, prdata, r;
   logic [7:0]  optByte = 8'hFF, flashRdData;
   logic [6:0]  erasePage;
   logic [4:0]  prev = 5'h1F;
   logic pready, pslverr, flashRdReq, flashRdValid, cpuHold, watchdogRunning;
   logic watchdogTimeoutAction, watchdogAlwaysOnN, codeReadProtectN;
   logic highSectorOnlyWritable, fullWritePermit, progGrant, progRefuse;
   logic eraseStart, eraseMass, eraseRefuse;
   int errors = 0, nCompared = 0, i, k;
   wire [4:0] opts = {watchdogTimeoutAction, watchdogAlwaysOnN,
      codeReadProtectN, highSectorOnlyWritable, fullWritePermit};
   obl_option_loader i_dut (.*);
   obl_flash_model i_flash (.*);
   initial forever #10 clk = ~clk;
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      nCompared++;
      if (s !== x) begin
         errors++;
         $display("[FAIL] %0t got %h want %h", $time, s, x);
      end
   endtask
   task automatic report_and_stop;
      if (errors == 0 && nCompared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Bounded wait for the hold on the processor to drop
   task automatic waitLoad;
      k = 0;
      do begin @(posedge clk); k++; end while (cpuHold !== 1'b0 && k < 40);
      if (cpuHold !== 1'b0) begin errors++; report_and_stop; end
   endtask
   // One APB transfer; read data and error kept in r and e
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge clk) penable <= 1;
      k = 0;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 9);
      if (pready !== 1'b1) begin errors++; report_and_stop; end
      r = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic erase(input logic [7:0] c);
      apb(obl_pkg::OFS_FLASH_CMD, 1, 32'h73);
      apb(obl_pkg::OFS_FLASH_CMD, 1, 32'h8C);
      apb(obl_pkg::OFS_FLASH_CMD, 1, {24'h0, c});
      @(posedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      chk({cpuHold, opts, watchdogRunning}, 7'h7E);
      rst_b <= 1;
      waitLoad;
      for (i = 0; i < 5; i++) begin
         optByte <= rows[i].opt; // Bits 5..3 kept one
         slow <= i[1];
         @(posedge clk);
         chk(opts, prev);
         if (i[0]) stopRecovery <= 1; else shortResetReq <= 1;
         @(posedge clk) {stopRecovery, shortResetReq} <= 2'b00;
         waitLoad;
         prev = {rows[i].opt[7:6], rows[i].opt[2:0]};
         chk(opts, prev);
         repeat (2) @(posedge clk);
         chk(watchdogRunning, !rows[i].opt[6]);
         progAddr <= {rows[i].pg, 9'h1FF};
         progReq <= 1;
         @(posedge clk) progReq <= 0;
         @(posedge clk);
         chk(progGrant, rows[i].ok);
         chk(progRefuse, !rows[i].ok);
      end
      watchdogStartInstruction <= 1;
      @(posedge clk) watchdogStartInstruction <= 0;
      repeat (2) @(posedge clk);
      chk(watchdogRunning, 1);
      apb(obl_pkg::OFS_PAGE_SEL, 1, 32'h7F);
      erase(8'h95);
      chk({eraseStart, eraseRefuse, eraseMass}, 3'b100);
      chk(erasePage, 32'h7F);
      erase(8'h63);
      chk({eraseStart, eraseRefuse, eraseMass}, 3'b011);
      debugMassErase <= 1;
      @(posedge clk) debugMassErase <= 0;
      @(posedge clk);
      chk({eraseStart, eraseMass}, 2'b11);
      // Status: loaded, reserved erased, refused, watchdog running
      apb(obl_pkg::OFS_STATUS, 0, 32'h0);
      chk(r, 32'hF);
      apb(obl_pkg::OFS_STATUS, 1, 32'h4);
      apb(obl_pkg::OFS_STATUS, 0, 32'h0);
      chk(r, 32'hB);
      apb(obl_pkg::OFS_PAGE_SEL, 0, 32'h0);
      chk(r, 32'h7F);
      // Lock state read back, then a wrong value relocks
      apb(obl_pkg::OFS_FLASH_CMD, 1, 32'h73);
      apb(obl_pkg::OFS_FLASH_CMD, 0, 32'h0);
      chk(r, 32'h1);
      apb(obl_pkg::OFS_FLASH_CMD, 1, 32'h0);
      apb(obl_pkg::OFS_FLASH_CMD, 0, 32'h0);
      chk(r, 32'h0);
      apb(12'h00C, 0, 32'h0);
      chk(r, 0);
      chk(e, 1);
      shortResetReq <= 1;
      @(posedge clk) shortResetReq <= 0;
      @(posedge clk);
      chk({cpuHold, watchdogRunning}, 2'b10);
      waitLoad;
      chk(opts, prev);
      report_and_stop;
   end
endmodule
